// ==== bench/upca_admission_tb.sv ====
// self-checking bench for the port b/c admission register bank
`timescale 1ns/1ps
module upca_admission_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [5:0] sar_out_fill = 6'h00;
   logic [3:0] porta_out_fill = 4'h0;
   logic [3:0] portb_out_fill = 4'h0;
   logic [3:0] portc_out_fill = 4'h0;
   logic portb_in_valid = 1'b0;
   logic [15:0] portb_in_data = 16'h0000;
   logic portb_in_ready, portb_cell_valid, portb_cell_ready, portb_sent, portc_cell_ok;
   logic [15:0] portb_cell_data;
   logic portc_cell_strobe = 1'b0;
   logic [11:0] portc_cell_vpi = 12'h000;
   logic [3:0] portc_table_base;
   logic [5:0] portc_table_log2_k;
   logic [4:0] portc_vci_bits;
   logic stall = 1'b0;
   int miscompares = 0;
   int samples_checked = 0;
   int exp_rx = 0;
   int exp_tx = 0;
   logic [15:0] rx_q[$];

   upca_admission #(.CELL_WIDTH(16)) uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sar_out_fill(sar_out_fill), .porta_out_fill(porta_out_fill), .portb_out_fill(portb_out_fill),
      .portc_out_fill(portc_out_fill), .portb_in_valid(portb_in_valid), .portb_in_data(portb_in_data),
      .portb_in_ready(portb_in_ready), .portb_cell_valid(portb_cell_valid), .portb_cell_data(portb_cell_data),
      .portb_cell_ready(portb_cell_ready), .portb_sent(portb_sent), .portc_cell_strobe(portc_cell_strobe),
      .portc_cell_vpi(portc_cell_vpi), .portc_cell_ok(portc_cell_ok), .portc_table_base(portc_table_base),
      .portc_table_log2_k(portc_table_log2_k), .portc_vci_bits(portc_vci_bits));
   upca_sink sink (.clk_sys(clk_sys), .rst(rst), .stall(stall), .cell_valid(portb_cell_valid),
      .cell_ready(portb_cell_ready), .sent(portb_sent));

   always #4 clk_sys = ~clk_sys;

   // record every popped word and every departure the far side reports
   always @(posedge clk_sys) begin
      if (!rst && portb_cell_ready && portb_cell_valid) rx_q.push_back(portb_cell_data);
      if (!rst && portb_sent) exp_tx++;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input string name, input logic [11:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      check(name, {16'h0000, reg_rdata}, {16'h0000, exp});
   endtask

   task automatic offer(input logic [15:0] d, output bit ok);
      ok = 0;
      @(posedge clk_sys);
      portb_in_valid <= 1'b1;
      portb_in_data <= d;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(posedge clk_sys);
         // ready launched by this edge reflects room and block state at it, i.e. the take
         #1;
         ok = (portb_in_ready === 1'b1);
      end
      portb_in_valid <= 1'b0;
      if (ok) exp_rx++;
   endtask

   task automatic set_fill(input int i, input logic [5:0] v);
      @(posedge clk_sys);
      sar_out_fill <= (i == 0) ? v : 6'h00;
      porta_out_fill <= (i == 1) ? v[3:0] : 4'h0;
      portb_out_fill <= (i == 2) ? v[3:0] : 4'h0;
      portc_out_fill <= (i == 3) ? v[3:0] : 4'h0;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic t_reset_rw;
      rd_chk("thr_a reset", 12'h64C, 16'h1108);
      rd_chk("thr_b reset", 12'h64E, 16'h0004);
      rd_chk("unmapped", 12'h668, 16'h0000);
      check("log2k reset", {26'h0, portc_table_log2_k}, 32'h7);
      wr(12'h64C, 16'h3FFF);
      rd_chk("thr_a mask", 12'h64C, 16'h3FFF);
      wr(12'h64E, 16'h000F);
      rd_chk("thr_b mask", 12'h64E, 16'h000F);
      wr(12'h664, 16'h0FFF);
      rd_chk("match mask", 12'h664, 16'h0FFF);
      wr(12'h652, 16'h1234);
      rd_chk("rx lo ro", 12'h652, 16'h0000);
      $display("test reset_rw done");
   endtask

   task automatic t_lut;
      for (int c = 0; c < 4; c++) begin
         wr(12'h660, 16'(c * 16 + 9 + c));
         wr(12'h662, 16'(17 + c));
         rd_chk("lut reg", 12'h660, 16'(c * 16 + 9 + c));
         check("base", {28'h0, portc_table_base}, 32'(9 + c));
         check("log2k", {26'h0, portc_table_log2_k}, 32'(7 + c));
         check("vci bits", {27'h0, portc_vci_bits}, 32'(17 + c));
      end
      $display("test lut done");
   endtask

   task automatic t_vpi;
      logic [11:0] v[4] = '{12'h0A5, 12'hFA5, 12'h0B5, 12'h005};
      logic exp[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      wr(12'h664, 16'h00A5);
      // mask still at reset zero: any vpi passes
      @(posedge clk_sys);
      portc_cell_strobe <= 1'b1;
      portc_cell_vpi <= 12'h35A;
      @(posedge clk_sys);
      portc_cell_strobe <= 1'b0;
      #1;
      check("vpi open", {31'h0, portc_cell_ok}, 32'h1);
      wr(12'h666, 16'h00F0);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         portc_cell_strobe <= 1'b1;
         portc_cell_vpi <= v[i];
         @(posedge clk_sys);
         portc_cell_strobe <= 1'b0;
         #1;
         check("vpi ok", {31'h0, portc_cell_ok}, {31'h0, exp[i]});
      end
      $display("test vpi done");
   endtask

   task automatic t_bp;
      logic [5:0] lim[4] = '{6'h10, 6'h05, 6'h03, 6'h06};
      bit ok;
      wr(12'h64C, 16'h0D50);
      wr(12'h64E, 16'h0006);
      for (int i = 0; i < 4; i++) begin
         set_fill(i, lim[i] + 6'h01);
         offer(16'h0B00, ok);
         check("blocked", 32'(ok), 32'h0);
         set_fill(i, lim[i]);
         offer(16'h0C00 + 16'(i), ok);
         check("at limit", 32'(ok), 32'h1);
      end
      wr(12'h64C, 16'h3FFF);
      wr(12'h64E, 16'h000F);
      @(posedge clk_sys);
      sar_out_fill <= 6'h3F;
      porta_out_fill <= 4'hF;
      portb_out_fill <= 4'hF;
      portc_out_fill <= 4'hF;
      repeat (3) @(posedge clk_sys);
      offer(16'h0D00, ok);
      check("disabled", 32'(ok), 32'h1);
      set_fill(0, 6'h00);
      $display("test backpressure done");
   endtask

   task automatic t_buf;
      bit ok;
      repeat (20) @(posedge clk_sys);
      rx_q.delete();
      stall <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         offer(16'hA001 + 16'(k), ok);
         check("stall fill", 32'(ok), (k < 2) ? 32'h1 : 32'h0);
      end
      stall <= 1'b0;
      repeat (20) @(posedge clk_sys);
      check("drained", 32'(rx_q.size()), 32'h2);
      for (int k = 0; k < 2 && k < rx_q.size(); k++) check("order", {16'h0, rx_q[k]}, 32'hA001 + 32'(k));
      $display("test buffer done");
   endtask

   task automatic t_count;
      rd_chk("rx hi", 12'h650, 16'h0000);
      rd_chk("rx lo", 12'h652, 16'(exp_rx));
      rd_chk("tx hi", 12'h654, 16'h0000);
      rd_chk("tx lo", 12'h656, 16'(exp_tx));
      check("all sent", 32'(exp_tx), 32'(exp_rx));
      $display("test counters done");
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset_rw();
      t_lut();
      t_vpi();
      t_bp();
      t_buf();
      t_count();
      give_verdict();
   end

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end
endmodule

// ==== bench/upca_sink.sv ====
// far-side cell sink: pops one word at a time and reports each word sent
`timescale 1ns/1ps
module upca_sink (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic stall,
   input wire logic cell_valid,
   output logic cell_ready,
   output logic sent
);
   logic [1:0] gap;
   // valid is a registered copy, so a pop is followed by three quiet cycles before valid is trusted again
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cell_ready <= 1'b0;
         sent <= 1'b0;
         gap <= 2'h0;
      end else begin
         cell_ready <= cell_valid && !stall && gap == 2'h0 && !cell_ready;
         sent <= cell_ready && cell_valid;
         gap <= cell_ready ? 2'h2 : (gap != 2'h0 ? gap - 2'h1 : 2'h0);
      end
   end
endmodule

// ==== common/upca_cell_if.sv ====
// cell handshake carrier between the admission top and its skid buffer
`timescale 1ns/1ps
interface upca_cell_if #(parameter int WIDTH = 16);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface

// ==== common/upca_pkg.sv ====
// package for the port b/c cell admission register bank
// Summary of operation
// - port b input cells are held back while the rx sar output fifo fill exceeds a 6-bit limit, all ones disabling it.
// - port b input cells are held back while the port a output fifo fill exceeds the 4-bit limit in bits 9:6, all ones disabling it.
// - port b input cells are held back while the port b output fifo fill exceeds the 4-bit limit in bits 13:10, all ones disabling it.
// - port b input cells are held back while the port c output fifo fill exceeds the 4-bit limit in bits 3:0 of the second register.
// - every cell received from port b is counted in 32 bits, read as upper and lower 16-bit words.
// - every cell sent on port b is counted in 32 bits, read as upper and lower 16-bit words.
// - the port c lookup table base in megabytes is a 4-bit field in bits 3:0.
// - the port c table size is bits 5:4, codes 0 to 3 giving 128K, 256K, 512K and 1024K entries.
// - the count of vci bits in the port c table index is a 5-bit field in bits 4:0.
// - a port c cell is valid only if each vpi bit selected by a mask one equals the 12-bit match value.
// - a 12-bit port c vpi mask at the next address selects which vpi bits must match.
package upca_pkg;
   localparam logic [11:0] ADDR_THR_A = 12'h64C;
   localparam logic [11:0] ADDR_THR_B = 12'h64E;
   localparam logic [11:0] ADDR_RX_HI = 12'h650;
   localparam logic [11:0] ADDR_RX_LO = 12'h652;
   localparam logic [11:0] ADDR_TX_HI = 12'h654;
   localparam logic [11:0] ADDR_TX_LO = 12'h656;
   localparam logic [11:0] ADDR_LUT_BASE = 12'h660;
   localparam logic [11:0] ADDR_VCI_NB = 12'h662;
   localparam logic [11:0] ADDR_VPI_MATCH = 12'h664;
   localparam logic [11:0] ADDR_VPI_MASK = 12'h666;
   localparam logic [15:0] RST_THR_A = 16'h1108;
   localparam logic [15:0] RST_THR_B = 16'h0004;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam int SAR_LSB = 0;
   localparam int OA_LSB = 6;
   localparam int OB_LSB = 10;
   localparam int OC_LSB = 0;
   localparam logic [5:0] SAR_OFF = 6'h3F;
   localparam logic [3:0] OUT_OFF = 4'hF;
   localparam logic [15:0] MASK_THR_A = 16'h3FFF;
   localparam logic [15:0] MASK_THR_B = 16'h000F;
   localparam logic [15:0] MASK_LUT = 16'h003F;
   localparam logic [15:0] MASK_VCI = 16'h001F;
   localparam logic [15:0] MASK_VPI = 16'h0FFF;
   localparam logic [2:0] SIZE_BASE_LOG2 = 3'h7; // 128K entries = 2^17, as 17-10
endpackage

// ==== verilog/upca_admission.sv ====
// port b admission, port b cell counters and port c lookup configuration
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module upca_admission #(
   parameter int CELL_WIDTH = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [11:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [5:0] sar_out_fill,
   input wire logic [3:0] porta_out_fill,
   input wire logic [3:0] portb_out_fill,
   input wire logic [3:0] portc_out_fill,
   input wire logic portb_in_valid,
   input wire logic [CELL_WIDTH-1:0] portb_in_data,
   output logic portb_in_ready,
   output logic portb_cell_valid,
   output logic [CELL_WIDTH-1:0] portb_cell_data,
   input wire logic portb_cell_ready,
   input wire logic portb_sent,
   input wire logic portc_cell_strobe,
   input wire logic [11:0] portc_cell_vpi,
   output logic portc_cell_ok,
   output logic [3:0] portc_table_base,
   output logic [5:0] portc_table_log2_k,
   output logic [4:0] portc_vci_bits
);
   logic [15:0] portb_backpressure_thresholds_a;
   logic [15:0] portb_backpressure_thresholds_b;
   logic [31:0] portb_received_cell_count;
   logic [31:0] portb_sent_cell_count;
   logic [15:0] portc_table_base_size;
   logic [15:0] portc_index_vci_width;
   logic [15:0] portc_path_id_compare;
   logic [15:0] portc_path_id_mask;
   logic [5:0] portb_in_sar_fill_limit;
   logic [3:0] portb_in_first_out_fill_limit;
   logic [3:0] portb_in_second_out_fill_limit;
   logic [3:0] portb_in_third_out_fill_limit;
   logic block_in;
   logic gate_valid;
   logic taken;
   logic [15:0] next_rdata;

   upca_cell_if #(.WIDTH(CELL_WIDTH)) in_c ();
   upca_cell_if #(.WIDTH(CELL_WIDTH)) out_c ();

   initial begin
      if (CELL_WIDTH < 1) $error("upca_admission: CELL_WIDTH must be at least 1");
   end

   // over-limit test; an all-ones limit never blocks
   function automatic logic over_limit(input logic [5:0] fill, input logic [5:0] limit,
                                       input logic [5:0] off);
      over_limit = (limit != off) && (fill > limit);
   endfunction

   // wrapping one-cell increment, no saturation
   function automatic logic [31:0] bump(input logic [31:0] cnt);
      bump = cnt + 32'h0000_0001;
   endfunction

   // field views of the threshold registers
   assign portb_in_sar_fill_limit = portb_backpressure_thresholds_a[upca_pkg::SAR_LSB +: 6];
   assign portb_in_first_out_fill_limit = portb_backpressure_thresholds_a[upca_pkg::OA_LSB +: 4];
   assign portb_in_second_out_fill_limit = portb_backpressure_thresholds_a[upca_pkg::OB_LSB +: 4];
   assign portb_in_third_out_fill_limit = portb_backpressure_thresholds_b[upca_pkg::OC_LSB +: 4];

   // any downstream fifo over its limit stops intake from port b
   assign block_in = over_limit(sar_out_fill, portb_in_sar_fill_limit, upca_pkg::SAR_OFF)
      || over_limit({2'h0, porta_out_fill}, {2'h0, portb_in_first_out_fill_limit},
                    {2'h0, upca_pkg::OUT_OFF})
      || over_limit({2'h0, portb_out_fill}, {2'h0, portb_in_second_out_fill_limit},
                    {2'h0, upca_pkg::OUT_OFF})
      || over_limit({2'h0, portc_out_fill}, {2'h0, portb_in_third_out_fill_limit},
                    {2'h0, upca_pkg::OUT_OFF});

   // cells enter the buffer only while not blocked
   assign gate_valid = portb_in_valid && !block_in;
   assign in_c.valid = gate_valid;
   assign in_c.data = portb_in_data;
   assign taken = gate_valid && in_c.ready;
   assign out_c.ready = portb_cell_ready;

   upca_skid #(.WIDTH(CELL_WIDTH)) u_skid (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_if(in_c.dst),
      .out_if(out_c.src)
   );

   // outward ports straight from flops; ready registered means a cell may be offered
   // one cycle late, so ready reflects last cycle's room and block state
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         portb_in_ready <= 1'b0;
      end else begin
         portb_in_ready <= in_c.ready && !block_in;
      end
   end

   // output view of the buffer head, registered
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         portb_cell_valid <= 1'b0;
         portb_cell_data <= '0;
      end else begin
         portb_cell_valid <= out_c.valid;
         portb_cell_data <= out_c.data;
      end
   end

   // host writes; reserved bits are kept zero by masking
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         portb_backpressure_thresholds_a <= upca_pkg::RST_THR_A;
         portb_backpressure_thresholds_b <= upca_pkg::RST_THR_B;
         portc_table_base_size <= upca_pkg::RST_ZERO;
         portc_index_vci_width <= upca_pkg::RST_ZERO;
         portc_path_id_compare <= upca_pkg::RST_ZERO;
         portc_path_id_mask <= upca_pkg::RST_ZERO;
      end else if (reg_wr) begin
         unique case (reg_addr)
            upca_pkg::ADDR_THR_A: portb_backpressure_thresholds_a <= reg_wdata & upca_pkg::MASK_THR_A;
            upca_pkg::ADDR_THR_B: portb_backpressure_thresholds_b <= reg_wdata & upca_pkg::MASK_THR_B;
            upca_pkg::ADDR_LUT_BASE: portc_table_base_size <= reg_wdata & upca_pkg::MASK_LUT;
            upca_pkg::ADDR_VCI_NB: portc_index_vci_width <= reg_wdata & upca_pkg::MASK_VCI;
            upca_pkg::ADDR_VPI_MATCH: portc_path_id_compare <= reg_wdata & upca_pkg::MASK_VPI;
            upca_pkg::ADDR_VPI_MASK: portc_path_id_mask <= reg_wdata & upca_pkg::MASK_VPI;
            default: ;
         endcase
      end
   end

   // arrival counter counts cells actually taken into the buffer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         portb_received_cell_count <= 32'h0000_0000;
      end else if (taken) begin
         portb_received_cell_count <= bump(portb_received_cell_count);
      end
   end

   // departure counter counts cells reported sent on port b
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         portb_sent_cell_count <= 32'h0000_0000;
      end else if (portb_sent) begin
         portb_sent_cell_count <= bump(portb_sent_cell_count);
      end
   end

   // lookup configuration outputs; size code turned into log2 of entries in K
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         portc_table_base <= 4'h0;
         portc_table_log2_k <= {3'h0, upca_pkg::SIZE_BASE_LOG2};
         portc_vci_bits <= 5'h00;
      end else begin
         portc_table_base <= portc_table_base_size[3:0];
         portc_table_log2_k <= {3'h0, upca_pkg::SIZE_BASE_LOG2} + {4'h0, portc_table_base_size[5:4]};
         portc_vci_bits <= portc_index_vci_width[4:0];
      end
   end

   // vpi filter result, one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         portc_cell_ok <= 1'b0;
      end else begin
         portc_cell_ok <= portc_cell_strobe &&
            (((portc_cell_vpi ^ portc_path_id_compare[11:0]) & portc_path_id_mask[11:0]) == 12'h000);
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = 16'h0000;
      unique case (reg_addr)
         upca_pkg::ADDR_THR_A: next_rdata = portb_backpressure_thresholds_a;
         upca_pkg::ADDR_THR_B: next_rdata = portb_backpressure_thresholds_b;
         upca_pkg::ADDR_RX_HI: next_rdata = portb_received_cell_count[31:16];
         upca_pkg::ADDR_RX_LO: next_rdata = portb_received_cell_count[15:0];
         upca_pkg::ADDR_TX_HI: next_rdata = portb_sent_cell_count[31:16];
         upca_pkg::ADDR_TX_LO: next_rdata = portb_sent_cell_count[15:0];
         upca_pkg::ADDR_LUT_BASE: next_rdata = portc_table_base_size;
         upca_pkg::ADDR_VCI_NB: next_rdata = portc_index_vci_width;
         upca_pkg::ADDR_VPI_MATCH: next_rdata = portc_path_id_compare;
         upca_pkg::ADDR_VPI_MASK: next_rdata = portc_path_id_mask;
         default: next_rdata = 16'h0000;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 16'h0000;
      end
   end

   // assertions: intake gating against each downstream fill limit
   sar_block_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (portb_in_sar_fill_limit != 6'h3F && sar_out_fill > portb_in_sar_fill_limit) |-> !taken)
      else $error("cell taken while sar fifo over limit");

   oa_block_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (portb_in_first_out_fill_limit != 4'hF && porta_out_fill > portb_in_first_out_fill_limit) |-> !taken)
      else $error("cell taken while port a fifo over limit");

   ob_block_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (portb_in_second_out_fill_limit != 4'hF && portb_out_fill > portb_in_second_out_fill_limit) |-> !taken)
      else $error("cell taken while port b fifo over limit");

   oc_block_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (portb_in_third_out_fill_limit != 4'hF && portc_out_fill > portb_in_third_out_fill_limit) |-> !taken)
      else $error("cell taken while port c fifo over limit");

   // a fill equal to its limit must not block; only strictly greater does
   intake_open_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (portb_in_valid && in_c.ready && sar_out_fill <= portb_in_sar_fill_limit
         && porta_out_fill <= portb_in_first_out_fill_limit && portb_out_fill <= portb_in_second_out_fill_limit
         && portc_out_fill <= portb_in_third_out_fill_limit) |-> taken)
      else $error("cell refused with every fifo at or under its limit");

   // all-ones limits switch backpressure off even with full fifos
   limits_off_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (portb_in_valid && in_c.ready && portb_in_sar_fill_limit == 6'h3F && portb_in_first_out_fill_limit == 4'hF
         && portb_in_second_out_fill_limit == 4'hF && portb_in_third_out_fill_limit == 4'hF) |-> taken)
      else $error("cell refused with every limit disabled");

   thr_a_read_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (reg_rd && reg_addr == upca_pkg::ADDR_THR_A) |=> reg_rdata == $past(portb_backpressure_thresholds_a))
      else $error("first threshold register read wrong");

   thr_b_write_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (reg_wr && reg_addr == upca_pkg::ADDR_THR_B) |=> portb_in_third_out_fill_limit == $past(reg_wdata[3:0]))
      else $error("port c fifo limit write lost");

   // cell counters: step per cell, hold otherwise, words read back as stored
   rx_count_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      taken |=> portb_received_cell_count == $past(portb_received_cell_count) + 32'h1)
      else $error("arrival counter did not step");

   rx_hold_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      !taken |=> portb_received_cell_count == $past(portb_received_cell_count))
      else $error("arrival counter moved without a cell");

   rx_hi_read_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (reg_rd && reg_addr == upca_pkg::ADDR_RX_HI) |=> reg_rdata == $past(portb_received_cell_count[31:16]))
      else $error("arrival upper word read wrong");

   rx_lo_read_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (reg_rd && reg_addr == upca_pkg::ADDR_RX_LO) |=> reg_rdata == $past(portb_received_cell_count[15:0]))
      else $error("arrival lower word read wrong");

   tx_count_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      !portb_sent |=> portb_sent_cell_count == $past(portb_sent_cell_count))
      else $error("departure counter moved without a cell");

   tx_hi_read_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (reg_rd && reg_addr == upca_pkg::ADDR_TX_HI) |=> reg_rdata == $past(portb_sent_cell_count[31:16]))
      else $error("departure upper word read wrong");

   tx_lo_read_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (reg_rd && reg_addr == upca_pkg::ADDR_TX_LO) |=> reg_rdata == $past(portb_sent_cell_count[15:0]))
      else $error("departure lower word read wrong");

   // 32-bit sum wraps by itself, so a stuck counter trips this on any cell and a saturating one at the wrap
   counter_wrap_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      portb_sent |=> portb_sent_cell_count == $past(portb_sent_cell_count) + 32'h1)
      else $error("departure counter did not step or wrap");

   // lookup configuration views
   table_base_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      ##1 portc_table_base == $past(portc_table_base_size[3:0]))
      else $error("table base output stale");

   lut_read_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (reg_rd && reg_addr == upca_pkg::ADDR_LUT_BASE) |=> reg_rdata == $past(portc_table_base_size))
      else $error("table base register read wrong");

   table_size_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (portc_table_base_size[5:4] == 2'h3) |=> portc_table_log2_k == 6'h0A)
      else $error("1024K size code misdecoded");

   vci_bits_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      ##1 portc_vci_bits == $past(portc_index_vci_width[4:0]))
      else $error("vci bit count output stale");

   // vpi filter: accept, reject and one-cycle pulse
   vpi_filter_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (portc_cell_strobe && portc_path_id_mask[11:0] == 12'h000) |=> portc_cell_ok)
      else $error("empty mask rejected a cell");

   vpi_reject_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (portc_cell_strobe && ((portc_cell_vpi ^ portc_path_id_compare[11:0]) & portc_path_id_mask[11:0]) != 12'h000)
      |=> !portc_cell_ok)
      else $error("masked vpi mismatch accepted");

   ok_pulse_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      !portc_cell_strobe |=> !portc_cell_ok)
      else $error("vpi result without a strobe");

   mask_write_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (reg_wr && reg_addr == 12'h666) |=> portc_path_id_mask == {4'h0, $past(reg_wdata[11:0])})
      else $error("vpi mask write lost");

   // read data must not linger past the cycle after the strobe
   rdata_idle_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data without a read strobe");
endmodule

// ==== verilog/upca_skid.sv ====
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module upca_skid #(
   parameter int WIDTH = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   upca_cell_if.dst in_if,
   upca_cell_if.src out_if
);
   logic [WIDTH-1:0] mem [0:1];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic push;
   logic pop;

   initial begin
      if (WIDTH < 1) $error("upca_skid: WIDTH must be at least 1");
   end

   // ready only while a slot is free, so a stalled reader loses nothing
   assign in_if.ready = (count != 2'h2);
   assign out_if.valid = (count != 2'h0);
   assign out_if.data = mem[rd_ptr];
   assign push = in_if.valid && in_if.ready;
   assign pop = out_if.valid && out_if.ready;

   // storage
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_if.data;
      end
   end

   // pointers and fill
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) wr_ptr <= ~wr_ptr;
         if (pop) rd_ptr <= ~rd_ptr;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

   buffer_bound_a: assert property (@(posedge clk_sys) disable iff (rst) count <= 2'h2)
      else $error("skid fill above two");
endmodule
